// file: common/rprs_consts.vh
// Constants for the run-permit interlock and relay output block.
// Assumes a single 20 MHz clock and a classic Wishbone register port.
`ifndef RPRS_CONSTS_VH
`define RPRS_CONSTS_VH
`define RPRS_NUM_IN 5
`define RPRS_FSEL_W 8
`define RPRS_OPT_RUN_PERMIT 8'h31
`define RPRS_OPT_RUN_SIGNAL 8'h00
`define RPRS_OPT_ALARM 8'h05
`define RPRS_OPT_FREQ_ARRIVE 8'h01
`define RPRS_FREQ_W 16
`define RPRS_ADR_W 4
// Word offsets (byte address = 4 * index)
`define RPRS_REG_IN_FSEL0 4'h0
`define RPRS_REG_IN_FSEL4 4'h4
`define RPRS_REG_CTRL 4'h5
`define RPRS_REG_OUT_FSEL 4'h6
`define RPRS_REG_START_FREQ 4'h7
`define RPRS_REG_OUT_FREQ 4'h8
`define RPRS_REG_STATUS 4'h9
`define RPRS_REG_TARGET_FREQ 4'hA
// Control register fields
`define RPRS_CTRL_KEY_RUN 0
`define RPRS_CTRL_NET_LOCK 1
`define RPRS_CTRL_ALARM 2
// Output select byte lanes
`define RPRS_OSEL_R11 7:0
`define RPRS_OSEL_R12 15:8
`define RPRS_OSEL_RAL 23:16
// Reset values and ramp step
`define RPRS_RST_FSEL 8'hFF
`define RPRS_RST_OSEL 24'h050100
`define RPRS_RST_START_FREQ 16'h0032
`define RPRS_RST_TARGET_FREQ 16'h1770
`define RPRS_FREQ_STEP 16'h0001
`endif

// file: rtl/rprs_in_sync.v
// Three-stage input synchroniser for terminal levels.
// Assumes the input is asynchronous to ref_clk; output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rprs_in_sync (
  input wire ref_clk, // System clock
  input wire rst_n, // Asynchronous reset, active low
  input wire async_in, // Raw terminal level
  output reg sync_out // Filtered synchronous level
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        sync_out <= s3;
    end
  end
endmodule
`default_nettype wire

// file: rtl/rprs_top.v
// Run-permit interlock and programmable relay outputs of a motor drive.
// Assumes terminal pins are asynchronous; registers are reached over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rprs_consts.vh"
module rprs_top (
  input wire ref_clk, // 20 MHz system clock
  input wire rst_n, // Asynchronous reset, active low
  input wire [`RPRS_NUM_IN-1:0] input_terminal, // Programmable input terminal pins
  input wire forward_run_command, // Forward run terminal pin
  input wire reverse_run_command, // Reverse run terminal pin
  input wire [31:0] wb_adr_i, // Wishbone byte address
  input wire [31:0] wb_dat_i, // Wishbone write data
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire wb_we_i, // Wishbone write enable
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  output reg wb_err_o, // Wishbone error for unmapped address
  output reg run_active, // Drive in run mode, output frequency above the start frequency setting
  output reg [`RPRS_FREQ_W-1:0] output_frequency, // Present output frequency
  output reg relay_11, // Form A relay 11 contact closed
  output reg relay_12, // Form A relay 12 contact closed
  output reg alarm_relay_contacts // Form C relay energised (normally-open side closed)
);
  // Synchronised terminals
  wire [`RPRS_NUM_IN-1:0] in_sync;
  wire fw_sync;
  wire rv_sync;
  genvar gi;
  generate
    for (gi = 0; gi < `RPRS_NUM_IN; gi = gi + 1) begin : g_in
      rprs_in_sync u_in (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(input_terminal[gi]),
        .sync_out(in_sync[gi])
      );
    end
  endgenerate
  rprs_in_sync u_fw (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(forward_run_command),
    .sync_out(fw_sync)
  );
  rprs_in_sync u_rv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(reverse_run_command),
    .sync_out(rv_sync)
  );

  // Configuration registers
  reg [`RPRS_FSEL_W-1:0] input_terminal_function_select [0:`RPRS_NUM_IN-1];
  reg key_run;
  reg net_lock;
  reg alarm_state;
  reg [23:0] out_sel;
  reg [`RPRS_FREQ_W-1:0] start_frequency_setting;
  reg [`RPRS_FREQ_W-1:0] target_freq;

  // Output function decode, shared by all three relays
  function out_func;
    input [7:0] code;
    input running;
    input alarm;
    input at_freq;
    begin
      case (code)
        `RPRS_OPT_RUN_SIGNAL: out_func = running;
        `RPRS_OPT_ALARM: out_func = alarm;
        `RPRS_OPT_FREQ_ARRIVE: out_func = at_freq;
        default: out_func = 1'b0;
      endcase
    end
  endfunction

  // Permit gating
  reg permit_assigned;
  reg permit_level;
  reg run_request;
  reg run_enable;
  integer k;
  always @* begin
    permit_assigned = 1'b0;
    permit_level = 1'b0;
    for (k = 0; k < `RPRS_NUM_IN; k = k + 1) begin
      if (input_terminal_function_select[k] == `RPRS_OPT_RUN_PERMIT) begin
        permit_assigned = 1'b1;
        permit_level = permit_level | in_sync[k];
      end
    end
    run_request = fw_sync | rv_sync | key_run;
    if (permit_assigned)
      run_enable = run_request & permit_level;
    else
      run_enable = fw_sync | rv_sync | key_run;
  end

  // Frequency ramp; enable gates the ramp target, output drops at once when lost
  wire [`RPRS_FREQ_W-1:0] next_output_frequency;
  assign next_output_frequency = !run_enable ? {`RPRS_FREQ_W{1'b0}} :
    (output_frequency < start_frequency_setting) ? start_frequency_setting :
    (output_frequency < target_freq) ? output_frequency + `RPRS_FREQ_STEP :
    output_frequency;
  wire running_now = run_enable && (output_frequency > start_frequency_setting);
  wire at_freq = run_enable && (output_frequency == target_freq);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_frequency <= {`RPRS_FREQ_W{1'b0}};
      run_active <= 1'b0;
      relay_11 <= 1'b0;
      relay_12 <= 1'b0;
      alarm_relay_contacts <= 1'b0;
    end else begin
      output_frequency <= next_output_frequency;
      run_active <= running_now;
      relay_11 <= out_func(out_sel[`RPRS_OSEL_R11], running_now, alarm_state, at_freq);
      relay_12 <= out_func(out_sel[`RPRS_OSEL_R12], running_now, alarm_state, at_freq);
      alarm_relay_contacts <= out_func(out_sel[`RPRS_OSEL_RAL], running_now, alarm_state,
        at_freq);
    end
  end

  // Wishbone slave: one-cycle ack, drop in following cycle
  wire [`RPRS_ADR_W-1:0] idx = wb_adr_i[`RPRS_ADR_W+1:2];
  wire mapped = (wb_adr_i[31:`RPRS_ADR_W+2] == 26'h0000000) &&
    (idx <= `RPRS_REG_TARGET_FREQ);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire wr = req && wb_we_i && mapped;
  reg [31:0] rd_data;
  integer j;

  always @* begin
    rd_data = 32'h00000000;
    if (idx <= `RPRS_REG_IN_FSEL4)
      rd_data = {24'h000000, input_terminal_function_select[idx[2:0]]};
    else begin
      case (idx)
        `RPRS_REG_CTRL: rd_data = {29'h00000000, alarm_state, net_lock, key_run};
        `RPRS_REG_OUT_FSEL: rd_data = {8'h00, out_sel};
        `RPRS_REG_START_FREQ: rd_data = {16'h0000, start_frequency_setting};
        `RPRS_REG_OUT_FREQ: rd_data = {16'h0000, output_frequency};
        `RPRS_REG_STATUS: rd_data = {24'h000000, in_sync, permit_assigned, permit_level,
          run_active};
        `RPRS_REG_TARGET_FREQ: rd_data = {16'h0000, target_freq};
        default: rd_data = 32'h00000000;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      key_run <= 1'b0;
      net_lock <= 1'b0;
      alarm_state <= 1'b0;
      out_sel <= `RPRS_RST_OSEL;
      start_frequency_setting <= `RPRS_RST_START_FREQ;
      target_freq <= `RPRS_RST_TARGET_FREQ;
      for (j = 0; j < `RPRS_NUM_IN; j = j + 1)
        input_terminal_function_select[j] <= `RPRS_RST_FSEL;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && mapped && !wb_we_i) ? rd_data : 32'h00000000;
      if (wr && wb_sel_i[0]) begin
        if (idx <= `RPRS_REG_IN_FSEL4) begin
          // Network writes never touch the permit code, in either direction
          if (!net_lock && wb_dat_i[7:0] != `RPRS_OPT_RUN_PERMIT &&
              input_terminal_function_select[idx[2:0]] != `RPRS_OPT_RUN_PERMIT)
            input_terminal_function_select[idx[2:0]] <= wb_dat_i[7:0];
        end else if (idx == `RPRS_REG_CTRL) begin
          key_run <= wb_dat_i[`RPRS_CTRL_KEY_RUN];
          net_lock <= wb_dat_i[`RPRS_CTRL_NET_LOCK];
          alarm_state <= wb_dat_i[`RPRS_CTRL_ALARM];
        end else if (idx == `RPRS_REG_START_FREQ)
          start_frequency_setting[7:0] <= wb_dat_i[7:0];
        else if (idx == `RPRS_REG_TARGET_FREQ)
          target_freq[7:0] <= wb_dat_i[7:0];
        else if (idx == `RPRS_REG_OUT_FSEL)
          out_sel[`RPRS_OSEL_R11] <= wb_dat_i[7:0];
      end
      if (wr && wb_sel_i[1]) begin
        if (idx == `RPRS_REG_START_FREQ)
          start_frequency_setting[15:8] <= wb_dat_i[15:8];
        else if (idx == `RPRS_REG_TARGET_FREQ)
          target_freq[15:8] <= wb_dat_i[15:8];
        else if (idx == `RPRS_REG_OUT_FSEL)
          out_sel[`RPRS_OSEL_R12] <= wb_dat_i[15:8];
      end
      if (wr && wb_sel_i[2] && idx == `RPRS_REG_OUT_FSEL)
        out_sel[`RPRS_OSEL_RAL] <= wb_dat_i[23:16];
    end
  end
endmodule
`default_nettype wire

// file: tb/rprs_checker_properties.sv
// Port checker for the run-permit and relay block.
// Assumes start frequency and relay 11 select stay at their reset values.
`timescale 1ns/1ps
`default_nettype none
module rprs_checker (
  input wire ref_clk, // Clock
  input wire rst_n, // Reset, active low
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Acknowledge
  input wire wb_err_o, // Error
  input wire run_active, // Running status
  input wire [15:0] output_frequency, // Output frequency
  input wire relay_11 // Relay 11
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ERR_PULSE: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
  AST_ANSWER_CAUSE: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  AST_ONE_ANSWER: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err");
  AST_DATA_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  AST_RUN_START: assert property (run_active |-> $past(output_frequency) > 16'h0032)
    else $error("running at or below start");
  AST_STOP_IDLE: assert property ($past(output_frequency) == 16'h0 |-> !run_active)
    else $error("running in stop");
  AST_RELAY_RUN: assert property ($changed(run_active) |-> ##[0:2] relay_11 == run_active)
    else $error("relay 11 not following run");
  AST_RAMP: assert property ((output_frequency != 0 && $past(output_frequency) != 0)
    |-> 16'(output_frequency - $past(output_frequency) + 16'h1) <= 16'h2) else $error("ramp jump");
  cover property ($rose(run_active));
  cover property ($fell(run_active));
  cover property (wb_err_o);
endmodule
bind rprs_top rprs_checker rprs_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .run_active(run_active), .output_frequency(output_frequency),
  .relay_11(relay_11));
`default_nettype wire

// file: tb/rprs_ctl_model.sv
// External controller that drives the run and terminal pins.
// Assumes the bench tells it which levels to hold.
`timescale 1ns/1ps
`default_nettype none
module rprs_ctl_model (
  input wire ref_clk, // Clock
  input wire fw_req, // Forward wanted
  input wire rv_req, // Reverse wanted
  input wire [4:0] term_req, // Terminal levels wanted
  output logic forward_run_command, // Forward pin
  output logic reverse_run_command, // Reverse pin
  output logic [4:0] input_terminal // Terminal pins
);
  initial begin
    forward_run_command = 1'b0;
    reverse_run_command = 1'b0;
    input_terminal = 5'h0;
  end
  // Levels held as long as asked: dropping one early stops the drive
  always @(posedge ref_clk) begin
    forward_run_command <= fw_req;
    reverse_run_command <= rv_req;
    input_terminal <= term_req;
  end
endmodule
`default_nettype wire

// file: tb/run_permit_and_run_status_test.sv
// Self-checking bench for the run-permit and relay block.
// Assumes the controller model owns the pins and the bench the register bus.
`timescale 1ns/1ps
`default_nettype none
`include "rprs_consts.vh"
module run_permit_and_run_status_test;
  logic ref_clk = 1'b0, rst_n = 1'b0, fw_req = 1'b0, rv_req = 1'b0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, err, run_active, r11, r12, ral, fwd, rev;
  logic [4:0] term_req = 5'h0, terms;
  logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, lfsr = 32'h2BA9;
  logic [3:0] sel = 4'h0;
  logic [15:0] freq;
  logic [7:0] exp_fsel [0:4];
  int n_mismatch = 0, compares = 0;
  always #25 ref_clk = ~ref_clk;
  rprs_ctl_model ctl (.ref_clk(ref_clk), .fw_req(fw_req), .rv_req(rv_req), .term_req(term_req),
    .forward_run_command(fwd), .reverse_run_command(rev), .input_terminal(terms));
  rprs_top rprs_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .input_terminal(terms),
    .forward_run_command(fwd), .reverse_run_command(rev), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .run_active(run_active), .output_frequency(freq),
    .relay_11(r11), .relay_12(r12), .alarm_relay_contacts(ral));
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // A select holding the permit code, or a write of it, leaves the old value
  function automatic logic [7:0] fsel_exp(input logic [7:0] old, input logic [7:0] wr);
    return (wr == `RPRS_OPT_RUN_PERMIT || old == `RPRS_OPT_RUN_PERMIT) ? old : wr;
  endfunction
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int i;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {26'h0, idx, 2'h0};
    dat <= d;
    sel <= 4'hF;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (!(ack === 1'b1 || err === 1'b1) && i < 20);
    q = dat_o;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (i >= 20) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic wait_run(input logic v);
    int i;
    for (i = 0; i < 400 && run_active !== v; i++) @(posedge ref_clk);
    check({31'h0, run_active}, {31'h0, v});
    if (i >= 400) begin
      n_mismatch++;
      complete_run();
    end
    repeat (2) @(posedge ref_clk);
    check({29'h0, r11, r12, ral}, {29'h0, {3{v}}});
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    int k;
    logic [7:0] v;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(0, `RPRS_REG_OUT_FSEL, 0, q, e);
    check(q, 32'h050100);
    wb(0, `RPRS_REG_START_FREQ, 0, q, e);
    check(q, 32'h32);
    for (k = 0; k < 5; k++) begin
      exp_fsel[k] = 8'hFF;
      wb(1, k[3:0], 32'h31, q, e);
      wb(0, k[3:0], 0, q, e);
      check(q, 32'hFF);
    end
    wb(0, `RPRS_REG_STATUS, 0, q, e);
    check(q & 32'h4, 32'h0);
    wb(0, 4'hB, 0, q, e);
    check({31'h0, e}, 32'h1);
    $display("register test done");
    for (k = 0; k < 12; k++) begin
      lfsr = next_lfsr(lfsr);
      v = (k % 4 == 3) ? 8'h31 : lfsr[7:0];
      term_req <= lfsr[12:8];
      wb(1, 4'(lfsr[18:16] % 5), {24'h0, v}, q, e);
      exp_fsel[lfsr[18:16] % 5] = fsel_exp(exp_fsel[lfsr[18:16] % 5], v);
      wb(0, 4'(lfsr[18:16] % 5), 0, q, e);
      check(q, {24'h0, exp_fsel[lfsr[18:16] % 5]});
    end
    $display("random select test done");
    wb(1, `RPRS_REG_TARGET_FREQ, 32'h40, q, e);
    wb(1, `RPRS_REG_OUT_FSEL, 32'h0, q, e);
    fw_req <= 1'b1;
    wait_run(1);
    check({31'h0, freq > 16'h0032}, 32'h1);
    fw_req <= 1'b0;
    wait_run(0);
    rv_req <= 1'b1;
    wait_run(1);
    rv_req <= 1'b0;
    wait_run(0);
    wb(1, `RPRS_REG_CTRL, 32'h1, q, e);
    wait_run(1);
    wb(1, `RPRS_REG_CTRL, 32'h0, q, e);
    wait_run(0);
    $display("run test done");
    complete_run();
  end
endmodule
`default_nettype wire
